/* cid_alu.sv */
`timescale 1ns/10ps
module cid_alu (
	input wire logic [3:0] op,
	input wire logic byte_mode,
	input wire logic [15:0] src,
	input wire logic [15:0] dst,
	input cid_pkg::cid_flags_type flags_in,
	output logic [15:0] res,
	output cid_pkg::cid_flags_type flags_out,
	output logic store
);
	import cid_pkg::*;

	logic [15:0] opnd;
	logic cin;
	logic [16:0] sum;
	logic [15:0] bcd;
	logic bcd_c;
	logic [4:0] nib;
	logic [15:0] msk;
	logic carry_out;
	logic sgn_s;
	logic sgn_d;
	logic sgn_r;
	logic zero;
	logic arith;

	always_comb begin
		opnd = src;
		cin = 1'b0;
		arith = 1'b1;
		case (op)
			// Decimal add stays off the binary flag path so its carry is the decimal one
			OP_ADD_WITH_CARRY: cin = flags_in.c;
			OP_SUB, OP_CMP: begin
				opnd = ~src;
				cin = 1'b1;
			end
			OP_SUBTRACT_WITH_CARRY: begin
				opnd = ~src;
				cin = flags_in.c;
			end
			OP_ADD: cin = 1'b0;
			default: arith = 1'b0;
		endcase
	end

	// Byte mode keeps the carry chain at bit 8 by masking the upper byte off
	assign msk = byte_mode ? 16'h00ff : 16'hffff;
	assign sum = {1'b0, dst & msk} + {1'b0, opnd & msk} + {16'h0000, cin};

	always_comb begin
		bcd = 16'h0000;
		bcd_c = flags_in.c;
		nib = 5'h00;
		for (int i = 0; i < 4; i++) begin
			nib = {1'b0, dst[i*4 +: 4]} + {1'b0, src[i*4 +: 4]} + {4'h0, bcd_c};
			if (nib > 5'h09) begin
				nib = nib + 5'h06;
			end
			if (!byte_mode || i < 2) begin
				bcd[i*4 +: 4] = nib[3:0];
				bcd_c = nib[4];
			end
		end
	end

	always_comb begin
		res = 16'h0000;
		store = 1'b1;
		case (op)
			OP_MOV: res = src;
			OP_DECIMAL_ADD: res = bcd;
			OP_BIT, OP_AND: res = src & dst;
			OP_BIC: res = ~src & dst;
			OP_BIS: res = src | dst;
			OP_XOR: res = src ^ dst;
			default: res = sum[15:0];
		endcase
		if (op == OP_CMP || op == OP_BIT) begin
			store = 1'b0;
		end
		res = res & msk;
	end

	assign carry_out = byte_mode ? sum[8] : sum[16];
	assign sgn_s = byte_mode ? opnd[7] : opnd[15];
	assign sgn_d = byte_mode ? dst[7] : dst[15];
	assign sgn_r = byte_mode ? res[7] : res[15];
	assign zero = (res & msk) == 16'h0000;

	always_comb begin
		flags_out = flags_in;
		if (arith) begin
			flags_out.c = carry_out;
			flags_out.v = (sgn_s == sgn_d) && (sgn_r != sgn_d);
			flags_out.n = sgn_r;
			flags_out.z = zero;
		end else if (op == OP_DECIMAL_ADD) begin
			flags_out.c = bcd_c;
			flags_out.v = (sgn_s == sgn_d) && (sgn_r != sgn_d);
			flags_out.n = sgn_r;
			flags_out.z = zero;
		end else if (op == OP_AND || op == OP_BIT) begin
			flags_out.v = 1'b0;
			flags_out.n = sgn_r;
			flags_out.z = zero;
			flags_out.c = !zero;
		end else if (op == OP_XOR) begin
			flags_out.v = sgn_s && sgn_d;
			flags_out.n = sgn_r;
			flags_out.z = zero;
			flags_out.c = !zero;
		end
	end
endmodule : cid_alu

/* cid_decode_top.sv */
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps
module cid_decode_top (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import cid_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} cid_state_type;

	cid_state_type state_r;
	cid_state_type state_nxt;
	logic [15:0] instr_r;
	logic [15:0] src_r;
	logic [15:0] dst_r;
	logic [1:0] evt_r;
	cid_flags_type flags_r;
	logic [15:0] result_r;
	logic store_r;
	cid_timing_type timing_r;
	logic [3:0] count_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	logic setup;
	logic access;
	logic wr;
	logic mapped;
	logic go;
	logic [1:0] go_evt;
	cid_timing_type dec;
	cid_timing_type evt_tim;
	logic [15:0] alu_res;
	cid_flags_type alu_flags;
	logic alu_store;
	logic [3:0] opcode;
	logic [3:0] sreg;
	logic [3:0] dreg;
	logic [1:0] as_bits;
	logic ad_bit;
	logic [2:0] subop;
	logic [1:0] skind;
	logic sext;
	logic [1:0] dkind;
	logic dext;

	// Source kind 0 reg, 1 indirect, 2 autoinc/imm, 3 indexed; constants from
	// the generator registers fetch no extension word and cost like a register.
	function automatic logic [1:0] src_kind(input logic [1:0] as_f, input logic [3:0] r);
		logic cg;
		cg = (r == REG_CG) || (r == REG_SR && as_f[1]);
		if (cg || as_f == AS_REG) begin
			return 2'h0;
		end else if (as_f == AS_IND) begin
			return 2'h1;
		end else if (as_f == AS_INC) begin
			return 2'h2;
		end
		return 2'h3;
	endfunction : src_kind

	function automatic logic src_ext(input logic [1:0] as_f, input logic [3:0] r);
		logic cg;
		cg = (r == REG_CG) || (r == REG_SR && as_f[1]);
		return !cg && (as_f == AS_IDX || (as_f == AS_INC && r == REG_PC));
	endfunction : src_ext

	assign setup = psel && !penable;
	assign access = psel && penable && pready_r;
	assign wr = access && pwrite;
	assign mapped = paddr == ADDR_INSTR || paddr == ADDR_SRC || paddr == ADDR_DST
		|| paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_RESULT
		|| paddr == ADDR_TIMING;
	assign go = wr && paddr == ADDR_CTRL && pwdata[CTRL_GO] && state_r == ST_IDLE;
	assign go_evt = pwdata[CTRL_EVT_LO +: 2];

	// Field split of the latched instruction word
	assign opcode = instr_r[15:12];
	assign sreg = instr_r[F_SREG_LO +: 4];
	assign dreg = instr_r[3:0];
	assign as_bits = instr_r[F_AS_LO +: 2];
	assign ad_bit = instr_r[F_AD];
	assign subop = instr_r[F_SUB_LO +: 3];
	assign skind = src_kind(as_bits, sreg);
	assign sext = src_ext(as_bits, sreg);
	assign dkind = src_kind(as_bits, dreg);
	assign dext = src_ext(as_bits, dreg);

	always_comb begin
		dec = '{cls: CLS_NONE, cycles: 4'h0, length: 2'h0, bad: 1'b1};
		if (opcode >= OP_MOV) begin
			dec.cls = CLS_DUAL;
			dec.bad = 1'b0;
			case (skind)
				2'h0: dec.cycles = CYC_SRC_R;
				2'h3: dec.cycles = CYC_SRC_X;
				default: dec.cycles = CYC_SRC_I;
			endcase
			if (ad_bit) begin
				dec.cycles = dec.cycles + CYC_DST_X;
			end else if (dreg == REG_PC) begin
				dec.cycles = dec.cycles + CYC_PC_EXTRA;
			end
			dec.length = LEN_ONE + {1'b0, sext} + {1'b0, ad_bit};
		end else if (opcode[3:1] == 3'h1) begin
			dec.cls = CLS_JUMP;
			dec.bad = 1'b0;
			dec.cycles = CYC_JUMP;
			dec.length = LEN_ONE;
		end else if (opcode == 4'h1 && instr_r[11:10] == 2'h0) begin
			dec.cls = CLS_SINGLE;
			dec.bad = 1'b0;
			dec.length = LEN_ONE + {1'b0, dext};
			case (subop)
				SUB_PUSH: dec.cycles = CYC_PUSH_TBL[dkind*4 +: 4];
				SUB_CALL: dec.cycles = CYC_CALL_TBL[dkind*4 +: 4];
				SUB_RETURN_FROM_INTERRUPT: begin
					dec.cycles = CYC_RETURN_FROM_INTERRUPT;
					dec.length = LEN_ONE;
				end
				3'h7: begin
					// Unused sub-operation is no instruction of any class
					dec.cls = CLS_NONE;
					dec.bad = 1'b1;
					dec.length = 2'h0;
				end
				default: begin
					dec.cycles = CYC_SHIFT_TBL[dkind*4 +: 4];
					// Immediate destination here is unpredictable; flagged, not run
					dec.bad = dkind == 2'h2 && dreg == REG_PC && as_bits == AS_INC;
				end
			endcase
		end
	end

	// Non-instruction activities carry no code words
	always_comb begin
		evt_tim = '{cls: CLS_NONE, cycles: CYC_IRQ, length: 2'h0, bad: 1'b0};
		case (go_evt)
			EVT_IRQ: evt_tim.cycles = CYC_IRQ;
			EVT_WDOG: evt_tim.cycles = CYC_WDOG;
			EVT_PIN: evt_tim.cycles = CYC_PIN;
			default: evt_tim = dec;
		endcase
	end

	cid_alu u_alu (
		.op(opcode),
		.byte_mode(instr_r[F_BW]),
		.src(src_r),
		.dst(dst_r),
		.flags_in(flags_r),
		.res(alu_res),
		.flags_out(alu_flags),
		.store(alu_store)
	);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (go && !evt_tim.bad && evt_tim.cycles > 4'h1) begin
					state_nxt = ST_BUSY;
				end
			end
			ST_BUSY: begin
				if (count_r == 4'h1) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Busy holds for exactly the cycle cost, one clock period per cycle; a cost of one cycle never sets busy
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			count_r <= 4'h0;
		end else if (go && !evt_tim.bad) begin
			count_r <= evt_tim.cycles;
		end else if (state_r == ST_BUSY) begin
			count_r <= count_r - 4'h1;
		end else begin
			count_r <= 4'h0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			timing_r <= '{cls: CLS_NONE, cycles: 4'h0, length: 2'h0, bad: 1'b0};
			evt_r <= EVT_INSTR;
		end else if (go) begin
			timing_r <= evt_tim;
			evt_r <= go_evt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			instr_r <= 16'h0000;
		end else if (wr && paddr == ADDR_INSTR && state_r == ST_IDLE) begin
			instr_r <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			src_r <= 16'h0000;
			dst_r <= 16'h0000;
		end else if (wr && state_r == ST_IDLE) begin
			if (paddr == ADDR_SRC) begin
				src_r <= pwdata[15:0];
			end
			if (paddr == ADDR_DST) begin
				dst_r <= pwdata[15:0];
			end
		end
	end

	// Dual-operand execution fires with the go strobe; the destination
	// register only changes for storing operations.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			result_r <= 16'h0000;
			store_r <= 1'b0;
		end else if (go && go_evt == EVT_INSTR && dec.cls == CLS_DUAL) begin
			result_r <= alu_store ? alu_res : dst_r;
			store_r <= alu_store;
		end else if (go) begin
			store_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flags_r <= '0;
		end else if (go && go_evt == EVT_INSTR && dec.cls == CLS_DUAL) begin
			flags_r <= alu_flags;
		end else if (wr && paddr == ADDR_STATUS) begin
			flags_r.c <= pwdata[SR_C];
			flags_r.z <= pwdata[SR_Z];
			flags_r.n <= pwdata[SR_N];
			flags_r.v <= pwdata[SR_V];
		end
	end

	// No wait state: read data is captured in the setup cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= setup;
			pslverr_r <= setup && !mapped;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata_r <= 32'h0000_0000;
			case (paddr)
				ADDR_INSTR: prdata_r[15:0] <= instr_r;
				ADDR_SRC: prdata_r[15:0] <= src_r;
				ADDR_DST: prdata_r[15:0] <= dst_r;
				ADDR_CTRL: prdata_r[CTRL_EVT_LO +: 2] <= evt_r;
				ADDR_STATUS: begin
					prdata_r[SR_C] <= flags_r.c;
					prdata_r[SR_Z] <= flags_r.z;
					prdata_r[SR_N] <= flags_r.n;
					prdata_r[SR_V] <= flags_r.v;
				end
				ADDR_RESULT: prdata_r[RES_STORE:0] <= {store_r, result_r};
				ADDR_TIMING: begin
					prdata_r[3:0] <= timing_r.cycles;
					prdata_r[TIM_LEN_LO +: 2] <= timing_r.length;
					prdata_r[TIM_CLS_LO +: 2] <= timing_r.cls;
					prdata_r[TIM_BUSY] <= state_r == ST_BUSY;
					prdata_r[TIM_BAD] <= timing_r.bad;
				end
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
endmodule : cid_decode_top

/* cid_decode_top_asserts.sv */
`timescale 1ns/10ps
module cid_chk_asserts (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	import cid_pkg::*;
	logic bad_addr;
	logic tim_rd;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	assign bad_addr = (paddr > ADDR_TIMING) || (paddr[1:0] != 2'h0);
	assign tim_rd = psel && penable && pready && !pwrite && (paddr == ADDR_TIMING);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence answer_s;
		psel && penable && pready;
	endsequence
	ready_next_a: assert property (setup_s |=> answer_s) else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	ready_access_a: assert property (pready |-> psel && penable) else $error("pready idle");
	err_unmapped_a: assert property (setup_s ##0 bad_addr |=> pslverr) else $error("no pslverr");
	err_mapped_a: assert property (setup_s ##0 !bad_addr |=> !pslverr) else $error("bad pslverr");
	err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
	jump_cost_a: assert property (tim_rd && prdata[9:8] == CLS_JUMP |-> prdata[5:0] == 6'h12)
		else $error("jump cost wrong");
	dual_len_a: assert property (tim_rd && prdata[9:8] == CLS_DUAL |->
		prdata[5:4] != 2'h0 && prdata[3:0] != 4'h0 && prdata[3:0] < 4'h8) else $error("dual cost");
	single_len_a: assert property (tim_rd && prdata[9:8] == CLS_SINGLE |->
		(prdata[5:4] == 2'h1 || prdata[5:4] == 2'h2) && prdata[3:0] < 4'h6) else $error("single len");
endmodule : cid_chk_asserts

bind cid_decode_top cid_chk_asserts i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr));

/* cid_pkg.sv */
package cid_pkg;
	localparam logic [7:0] ADDR_INSTR = 8'h00;
	localparam logic [7:0] ADDR_SRC = 8'h04;
	localparam logic [7:0] ADDR_DST = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_RESULT = 8'h14;
	localparam logic [7:0] ADDR_TIMING = 8'h18;

	// Status register bit positions
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_N = 2;
	localparam int SR_V = 8;

	// Control register fields
	localparam int CTRL_GO = 0;
	localparam int CTRL_EVT_LO = 1;
	localparam logic [1:0] EVT_INSTR = 2'h0;
	localparam logic [1:0] EVT_IRQ = 2'h1;
	localparam logic [1:0] EVT_WDOG = 2'h2;
	localparam logic [1:0] EVT_PIN = 2'h3;

	// Timing register fields; RES_STORE is the result register store bit
	localparam int TIM_LEN_LO = 4;
	localparam int TIM_CLS_LO = 8;
	localparam int TIM_BUSY = 12;
	localparam int TIM_BAD = 13;
	localparam int RES_STORE = 16;

	// Instruction word fields
	localparam int F_SREG_LO = 8;
	localparam int F_AD = 7;
	localparam int F_BW = 6;
	localparam int F_AS_LO = 4;
	localparam int F_SUB_LO = 7;
	localparam logic [3:0] REG_PC = 4'h0;
	localparam logic [3:0] REG_SR = 4'h2;
	localparam logic [3:0] REG_CG = 4'h3;

	localparam logic [1:0] AS_REG = 2'h0;
	localparam logic [1:0] AS_IDX = 2'h1;
	localparam logic [1:0] AS_IND = 2'h2;
	localparam logic [1:0] AS_INC = 2'h3;

	localparam logic [1:0] CLS_NONE = 2'h0;
	localparam logic [1:0] CLS_DUAL = 2'h1;
	localparam logic [1:0] CLS_SINGLE = 2'h2;
	localparam logic [1:0] CLS_JUMP = 2'h3;

	// Single-operand sub-opcodes
	localparam logic [2:0] SUB_PUSH = 3'h4;
	localparam logic [2:0] SUB_CALL = 3'h5;
	localparam logic [2:0] SUB_RETURN_FROM_INTERRUPT = 3'h6;

	// Dual-operand opcodes
	localparam logic [3:0] OP_MOV = 4'h4;
	localparam logic [3:0] OP_ADD = 4'h5;
	localparam logic [3:0] OP_ADD_WITH_CARRY = 4'h6;
	localparam logic [3:0] OP_SUBTRACT_WITH_CARRY = 4'h7;
	localparam logic [3:0] OP_SUB = 4'h8;
	localparam logic [3:0] OP_CMP = 4'h9;
	localparam logic [3:0] OP_DECIMAL_ADD = 4'ha;
	localparam logic [3:0] OP_BIT = 4'hb;
	localparam logic [3:0] OP_BIC = 4'hc;
	localparam logic [3:0] OP_BIS = 4'hd;
	localparam logic [3:0] OP_XOR = 4'he;
	localparam logic [3:0] OP_AND = 4'hf;

	// Cycle costs; source kind index 0 reg, 1 indirect, 2 autoinc/imm, 3 indexed
	localparam logic [3:0] CYC_SRC_R = 4'h1;
	localparam logic [3:0] CYC_SRC_I = 4'h2;
	localparam logic [3:0] CYC_SRC_X = 4'h3;
	localparam logic [3:0] CYC_DST_X = 4'h3;
	localparam logic [3:0] CYC_PC_EXTRA = 4'h1;
	localparam logic [15:0] CYC_SHIFT_TBL = 16'h4331;
	localparam logic [15:0] CYC_PUSH_TBL = 16'h5443;
	localparam logic [15:0] CYC_CALL_TBL = 16'h5544;
	localparam logic [3:0] CYC_JUMP = 4'h2;
	localparam logic [3:0] CYC_RETURN_FROM_INTERRUPT = 4'h5;
	localparam logic [3:0] CYC_IRQ = 4'h6;
	localparam logic [3:0] CYC_WDOG = 4'h4;
	localparam logic [3:0] CYC_PIN = 4'h4;
	localparam logic [1:0] LEN_ONE = 2'h1;

	typedef struct packed {
		logic v;
		logic n;
		logic z;
		logic c;
	} cid_flags_type;

	typedef struct packed {
		logic [1:0] cls;
		logic [3:0] cycles;
		logic [1:0] length;
		logic bad;
	} cid_timing_type;
endpackage : cid_pkg

/* cid_prog_mem.sv */
`timescale 1ns/10ps
module cid_prog_mem (
	input wire logic [3:0] addr,
	output logic [15:0] word
);
	import cid_pkg::*;
	// Holds legal code only: no shift-group op with an immediate destination
	always_comb begin
		if (addr < 4'h8) begin
			word = 16'h2000 | {3'h0, addr[2:0], 10'h03f};
		end else begin
			word = 16'h1300;
		end
	end
endmodule : cid_prog_mem

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
	import cid_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] rom_addr = 4'h0;
	logic [15:0] rom_word;
	logic [31:0] rd;
	logic [31:0] tim;
	logic err;
	int err_count = 0;
	int checks_done = 0;

	cid_decode_top i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	cid_prog_mem i_mem (.addr(rom_addr), .word(rom_word));

	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	task test_done;
		if (err_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk_sys);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, pready}, 32'h1);
	endtask : apb

	// Waits out busy so the next GO is not silently dropped
	task go(input logic [15:0] ins, input logic [1:0] evt);
		int n;
		n = 0;
		apb(1'b1, ADDR_INSTR, {16'h0, ins});
		apb(1'b1, ADDR_CTRL, {29'h0, evt, 1'b1});
		apb(1'b0, ADDR_TIMING, 32'h0);
		tim = rd;
		while (rd[TIM_BUSY] !== 1'b0 && n < 20) begin
			n++;
			apb(1'b0, ADDR_TIMING, 32'h0);
		end
		chk({31'h0, rd[TIM_BUSY]}, 32'h0);
	endtask : go

	function automatic logic [31:0] tword(logic [3:0] c, logic [1:0] l, logic [1:0] k, logic b);
		return {18'h0, b, 3'h0, k, 2'h0, l, c};
	endfunction : tword

	task dual_case(input logic [1:0] as, input logic ad, input logic [3:0] s, input logic [3:0] d);
		logic [15:0] tb;
		logic [3:0] cyc;
		logic [1:0] len;
		tb = ad ? 16'h5564 : 16'h2231;
		cyc = tb[as*4 +: 4] + {3'h0, !ad && d == REG_PC};
		len = 2'h1 + {1'b0, as == AS_IDX || (as == AS_INC && s == REG_PC)} + {1'b0, ad};
		go({OP_MOV, s, ad, 1'b0, as, d}, EVT_INSTR);
		chk(tim & 32'h233f, tword(cyc, len, CLS_DUAL, 1'b0));
	endtask : dual_case

	task single_case(input logic [2:0] sub, input logic [1:0] as, input logic [3:0] r);
		logic [15:0] tb;
		logic [1:0] len;
		logic bad;
		tb = sub == SUB_PUSH ? 16'h4453 : (sub == SUB_CALL ? 16'h5454 : 16'h3341);
		len = 2'h1 + {1'b0, as == AS_IDX || (as == AS_INC && r == REG_PC)};
		bad = sub < SUB_PUSH && as == AS_INC && r == REG_PC;
		go({6'h04, sub, 1'b0, as, r}, EVT_INSTR);
		chk(tim & 32'h233f, tword(tb[as*4 +: 4], len, CLS_SINGLE, bad));
	endtask : single_case

	task alu_case(input logic [3:0] op, input logic bw, input logic [15:0] s, input logic [15:0] d,
		input logic [15:0] st, input logic [16:0] res, input logic [15:0] stx);
		apb(1'b1, ADDR_SRC, {16'h0, s});
		apb(1'b1, ADDR_DST, {16'h0, d});
		apb(1'b1, ADDR_STATUS, {16'h0, st});
		go({op, 4'h4, 1'b0, bw, AS_REG, 4'h5}, EVT_INSTR);
		apb(1'b0, ADDR_RESULT, 32'h0);
		chk(rd, {15'h0, res});
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, {16'h0, stx});
	endtask : alu_case

	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int a = 0; a < 28; a += 4) begin
			apb(1'b0, a[7:0], 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, 8'h02, 32'h0);
		chk({31'h0, err}, 32'h1);
		for (int s = 0; s < 2; s++) begin
			for (int a = 0; a < 8; a++) begin
				for (int d = 0; d < 2; d++) begin
					dual_case(a[1:0], a[2], s[0] ? REG_PC : 4'h4, d[0] ? REG_PC : 4'h5);
				end
			end
		end
		for (int k = 0; k < 6; k++) begin
			for (int a = 0; a < 8; a++) begin
				single_case(k[2:0], a[1:0], a[2] ? REG_PC : 4'h5);
			end
		end
		for (int i = 0; i < 9; i++) begin
			rom_addr = i[3:0];
			#1;
			go(rom_word, EVT_INSTR);
			chk(tim & 32'h233f, i < 8 ? tword(4'h2, 2'h1, CLS_JUMP, 1'b0) :
				tword(4'h5, 2'h1, CLS_SINGLE, 1'b0));
		end
		for (int e = 1; e < 4; e++) begin
			go(16'h0, e[1:0]);
			chk(tim & 32'hf, e == 1 ? 32'h6 : 32'h4);
			apb(1'b0, ADDR_CTRL, 32'h0);
			chk(rd & 32'h6, {29'h0, e[1:0], 1'b0});
		end
		apb(1'b1, ADDR_INSTR, 32'h0000_4495);
		apb(1'b1, ADDR_CTRL, 32'h1);
		apb(1'b1, ADDR_INSTR, 32'h0);
		apb(1'b0, ADDR_INSTR, 32'h0);
		chk(rd, 32'h0000_4495);
		go(16'h2000, EVT_INSTR);
		go(16'h1380, EVT_INSTR);
		chk(tim & 32'h233f, tword(4'h0, 2'h0, CLS_NONE, 1'b1));
		alu_case(OP_ADD_WITH_CARRY, 1'b0, 16'h7fff, 16'h0000, 16'h0001, 17'h18000, 16'h0104);
		alu_case(OP_DECIMAL_ADD, 1'b0, 16'h0019, 16'h0001, 16'h0001, 17'h10021, 16'h0000);
		alu_case(OP_DECIMAL_ADD, 1'b0, 16'h9999, 16'h0001, 16'h0000, 17'h10000, 16'h0003);
		alu_case(OP_ADD, 1'b0, 16'hffff, 16'h0001, 16'h0001, 17'h10000, 16'h0003);
		alu_case(OP_SUB, 1'b0, 16'h0005, 16'h0005, 16'h0000, 17'h10000, 16'h0003);
		alu_case(OP_SUBTRACT_WITH_CARRY, 1'b0, 16'h0005, 16'h0005, 16'h0000, 17'h1ffff, 16'h0004);
		alu_case(OP_CMP, 1'b0, 16'h0005, 16'h0005, 16'h0000, 17'h00005, 16'h0003);
		alu_case(OP_BIT, 1'b0, 16'h8001, 16'h8000, 16'h0100, 17'h08000, 16'h0005);
		alu_case(OP_AND, 1'b0, 16'h8001, 16'h8000, 16'h0100, 17'h18000, 16'h0005);
		alu_case(OP_XOR, 1'b0, 16'h8000, 16'h8000, 16'h0000, 17'h10000, 16'h0102);
		alu_case(OP_MOV, 1'b0, 16'h1234, 16'h0000, 16'h0107, 17'h11234, 16'h0107);
		alu_case(OP_BIC, 1'b0, 16'h00f0, 16'h0ff0, 16'h0103, 17'h10f00, 16'h0103);
		alu_case(OP_BIS, 1'b0, 16'h000f, 16'h0f00, 16'h0104, 17'h10f0f, 16'h0104);
		alu_case(OP_ADD_WITH_CARRY, 1'b1, 16'h00ff, 16'h1201, 16'h0000, 17'h10000, 16'h0003);
		alu_case(OP_SUB, 1'b1, 16'h0001, 16'hff00, 16'h0000, 17'h100ff, 16'h0004);
		test_done;
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		test_done;
	end
endmodule : testbench
